// >>> logic/sgmr_params.svh
// constants of the per-channel link management register set
// assumes a 5-bit register address and 16-bit register words
`ifndef SGMR_PARAMS_SVH
`define SGMR_PARAMS_SVH

// register addresses within one channel
`define SGMR_ADDR_CTRL 5'h00
`define SGMR_ADDR_STAT 5'h01
`define SGMR_ADDR_ID_HI 5'h02
`define SGMR_ADDR_ID_LO 5'h03
`define SGMR_ADDR_EXT 5'h0F
`define SGMR_ADDR_GEN 5'h12

// control word field positions
`define SGMR_CTL_RESET 15
`define SGMR_CTL_RSVD14 14
`define SGMR_CTL_SPEED_LSB 13
`define SGMR_CTL_AN_EN 12
`define SGMR_CTL_PDOWN 11
`define SGMR_CTL_ISOLATE 10
`define SGMR_CTL_AN_RESTART 9
`define SGMR_CTL_DUPLEX 8
`define SGMR_CTL_COL_TEST 7
`define SGMR_CTL_SPEED_MSB 6
`define SGMR_CTL_UNIDIR 5

// status and generic control field positions
`define SGMR_STAT_LINK 2
`define SGMR_GEN_DISP 0

// constant read values
`define SGMR_CTL_SPEED_LSB_VAL 1'b0
`define SGMR_CTL_DUPLEX_VAL 1'b1
`define SGMR_CTL_COL_TEST_VAL 1'b0
`define SGMR_CTL_SPEED_MSB_VAL 1'b1
`define SGMR_CTL_LOW_VAL 5'h00
`define SGMR_STAT_CONST 16'h01C8
`define SGMR_EXT_VAL 16'h8000
`define SGMR_ID_HI_VAL 16'h0000
`define SGMR_GEN_HIGH_VAL 15'h0000
`define SGMR_ZERO_WORD 16'h0000

// reset values of stored bits
`define SGMR_RST_RSVD14 1'b0
`define SGMR_RST_AN_EN 1'b1
`define SGMR_RST_BIT11 1'b0
`define SGMR_RST_ISOLATE 1'b1
`define SGMR_RST_AN_RESTART 1'b0
`define SGMR_RST_UNIDIR 1'b0
`define SGMR_RST_DISP 1'b0
`define SGMR_RST_LINK 1'b0

`endif

// >>> logic/sgmr_pkg.sv
// types shared by the management register set
// assumes nothing of its surroundings
package sgmr_pkg;
	// per-channel module reset handshake
	typedef enum logic [0:0] {
		SGMR_RST_IDLE,
		SGMR_RST_HOLD
	} sgmr_rst_e;
endpackage

// >>> logic/sgmr_sync.sv
// three-stage synchroniser for pin-level inputs
// assumes inputs are asynchronous to sys_clk_i; output moves only
// once the second and third stages agree
module sgmr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // async reset, active high
	input wire logic [WIDTH-1:0] async_i, // raw pin levels
	output logic [WIDTH-1:0] sync_o // filtered levels
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	wire [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_o <= '0;
		end else begin
			sync_o <= (agree & s3_r) | (~agree & sync_o);
		end
	end
endmodule // sgmr_sync

// >>> logic/sgmr_regs.sv
// management register set for all channels of the serial gigabit core
// assumes an upstream management frame decoder that presents one access
// per strobe with channel, address and data; link and reset-done come
// from pins or other domains and are synchronised here
`include "sgmr_params.svh"

module sgmr_regs #(
	parameter int NCHAN = 4,
	parameter logic [15:0] ID_LO_VAL = 16'h0000 // arbitrary neutral value
) (
	input wire logic sys_clk_i, // system clock, 25 MHz
	input wire logic rst_i, // async reset, active high
	input wire logic [1:0] reg_chan_i, // channel of the access
	input wire logic [4:0] reg_addr_i, // register address
	input wire logic reg_wr_i, // write strobe, one cycle
	input wire logic reg_rd_i, // read strobe, one cycle
	input wire logic [15:0] reg_wdata_i, // write data
	output logic [15:0] reg_rdata_o, // read data, held until next read
	output logic reg_rvalid_o, // read data valid, one cycle
	input wire logic [NCHAN-1:0] link_up_i, // serial link up, async
	input wire logic [NCHAN-1:0] reset_done_i, // module took its reset
	output logic [NCHAN-1:0] chan_reset_o, // module reset request
	output logic [NCHAN-1:0] autoneg_en_o, // autoneg enable
	output logic [NCHAN-1:0] autoneg_restart_o, // autoneg restart pulse
	output logic power_down_o, // channel 0 transceiver low power
	output logic [NCHAN-1:0] isolate_o, // isolate client interface
	output logic [NCHAN-1:0] unidir_en_o, // transmit without link
	output logic [NCHAN-1:0] disparity_en_o // disparity checking on
);
	localparam int CW = 2;

	logic [NCHAN-1:0] link_s;
	logic [NCHAN-1:0] done_s;
	logic [15:0] chan_word [NCHAN];
	logic [NCHAN-1:0] pdown_bits;

	// link state and reset acknowledge arrive from outside the domain
	sgmr_sync #(
		.WIDTH(2 * NCHAN)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i({reset_done_i, link_up_i}),
		.sync_o({done_s, link_s})
	);

	genvar g;
	for (g = 0; g < NCHAN; g++) begin : g_chan
		sgmr_pkg::sgmr_rst_e st_r;
		sgmr_pkg::sgmr_rst_e st_nxt;
		logic rsvd14_r;
		logic an_en_r;
		logic bit11_r;
		logic isolate_r;
		logic restart_r;
		logic unidir_r;
		logic disp_r;
		logic link_r;
		logic rst_req_r;

		wire sel = reg_chan_i == CW'(g);
		wire idle = st_r == sgmr_pkg::SGMR_RST_IDLE;
		wire hit_ctl = sel & (reg_addr_i == `SGMR_ADDR_CTRL);
		wire hit_stat = sel & (reg_addr_i == `SGMR_ADDR_STAT);
		wire hit_gen = sel & (reg_addr_i == `SGMR_ADDR_GEN);
		// writes are dropped while the module reset is outstanding
		wire wr_ctl = reg_wr_i & hit_ctl & idle;
		wire wr_gen = reg_wr_i & hit_gen & idle;
		wire rd_stat = reg_rd_i & hit_stat;
		wire go_rst = wr_ctl & reg_wdata_i[`SGMR_CTL_RESET];
		wire w_bit11 = reg_wdata_i[`SGMR_CTL_PDOWN];
		// on channel 0 a write without the reset bit can only set power-down
		wire bit11_nxt = (g == 0) ? (bit11_r | w_bit11) : w_bit11;
		// a link drop in the read cycle still wins over the reload
		wire link_nxt = rd_stat ? link_s[g] : (link_r & link_s[g]);

		always_comb begin
			st_nxt = st_r;
			case (st_r)
				sgmr_pkg::SGMR_RST_IDLE: begin
					if (go_rst) begin
						st_nxt = sgmr_pkg::SGMR_RST_HOLD;
					end
				end
				sgmr_pkg::SGMR_RST_HOLD: begin
					if (done_s[g]) begin
						st_nxt = sgmr_pkg::SGMR_RST_IDLE;
					end
				end
				default: begin
					st_nxt = sgmr_pkg::SGMR_RST_IDLE;
				end
			endcase
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				st_r <= sgmr_pkg::SGMR_RST_IDLE;
				rst_req_r <= 1'b0;
			end else begin
				st_r <= st_nxt;
				rst_req_r <= st_nxt == sgmr_pkg::SGMR_RST_HOLD;
			end
		end

		// a module reset reloads this channel's defaults and nothing else
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				rsvd14_r <= `SGMR_RST_RSVD14;
				an_en_r <= `SGMR_RST_AN_EN;
				bit11_r <= `SGMR_RST_BIT11;
				isolate_r <= `SGMR_RST_ISOLATE;
				unidir_r <= `SGMR_RST_UNIDIR;
			end else if (go_rst) begin
				rsvd14_r <= `SGMR_RST_RSVD14;
				an_en_r <= `SGMR_RST_AN_EN;
				bit11_r <= `SGMR_RST_BIT11;
				isolate_r <= `SGMR_RST_ISOLATE;
				unidir_r <= `SGMR_RST_UNIDIR;
			end else if (wr_ctl) begin
				rsvd14_r <= reg_wdata_i[`SGMR_CTL_RSVD14];
				an_en_r <= reg_wdata_i[`SGMR_CTL_AN_EN];
				bit11_r <= bit11_nxt;
				isolate_r <= reg_wdata_i[`SGMR_CTL_ISOLATE];
				unidir_r <= reg_wdata_i[`SGMR_CTL_UNIDIR];
			end
		end

		// restart is a single pulse, accepted at once, so it reads 0 after
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				restart_r <= `SGMR_RST_AN_RESTART;
			end else begin
				restart_r <= wr_ctl & ~go_rst &
					reg_wdata_i[`SGMR_CTL_AN_RESTART];
			end
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				disp_r <= `SGMR_RST_DISP;
			end else if (go_rst) begin
				disp_r <= `SGMR_RST_DISP;
			end else if (wr_gen) begin
				disp_r <= reg_wdata_i[`SGMR_GEN_DISP];
			end
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				link_r <= `SGMR_RST_LINK;
			end else begin
				link_r <= link_nxt;
			end
		end

		wire [15:0] ctl_word = {
			~idle,
			rsvd14_r,
			`SGMR_CTL_SPEED_LSB_VAL,
			an_en_r,
			bit11_r,
			isolate_r,
			restart_r,
			`SGMR_CTL_DUPLEX_VAL,
			`SGMR_CTL_COL_TEST_VAL,
			`SGMR_CTL_SPEED_MSB_VAL,
			unidir_r,
			`SGMR_CTL_LOW_VAL
		};
		// only bit 2 of status is live; medium state is not held here
		wire [15:0] stat_word = `SGMR_STAT_CONST |
			{13'h0, link_r, 2'b00};
		wire [15:0] gen_word = {`SGMR_GEN_HIGH_VAL, disp_r};

		always_comb begin
			case (reg_addr_i)
				`SGMR_ADDR_CTRL: chan_word[g] = ctl_word;
				`SGMR_ADDR_STAT: chan_word[g] = stat_word;
				`SGMR_ADDR_ID_HI: chan_word[g] = `SGMR_ID_HI_VAL;
				`SGMR_ADDR_ID_LO: chan_word[g] = ID_LO_VAL;
				`SGMR_ADDR_EXT: chan_word[g] = `SGMR_EXT_VAL;
				`SGMR_ADDR_GEN: chan_word[g] = gen_word;
				default: chan_word[g] = `SGMR_ZERO_WORD;
			endcase
		end

		assign chan_reset_o[g] = rst_req_r;
		assign autoneg_en_o[g] = an_en_r;
		assign autoneg_restart_o[g] = restart_r;
		assign isolate_o[g] = isolate_r;
		assign unidir_en_o[g] = unidir_r;
		assign disparity_en_o[g] = disp_r;
		assign pdown_bits[g] = bit11_r;
	end

	// only channel 0 gives bit 11 a power-down meaning
	assign power_down_o = pdown_bits[0];

	// a channel number of NCHAN or above reads as an undefined address
	wire chan_ok = int'(reg_chan_i) < NCHAN;
	wire [15:0] rd_word = chan_ok ? chan_word[reg_chan_i] : `SGMR_ZERO_WORD;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= `SGMR_ZERO_WORD;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_word;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
		end
	end
endmodule // sgmr_regs

// >>> test/sgmr_regs_props.sv
// assertion checker for the channel management register set
// assumes it is bound to sgmr_regs and sees only its ports
module sgmr_regs_props #(
	parameter int NCHAN = 4
) (
	input wire logic sys_clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [1:0] reg_chan_i, // channel
	input wire logic [4:0] reg_addr_i, // address
	input wire logic reg_wr_i, // write
	input wire logic reg_rd_i, // read
	input wire logic [15:0] reg_wdata_i, // write data
	input wire logic [15:0] reg_rdata_o, // read data
	input wire logic reg_rvalid_o, // read valid
	input wire logic [NCHAN-1:0] reset_done_i, // reset taken
	input wire logic [NCHAN-1:0] chan_reset_o, // reset request
	input wire logic [NCHAN-1:0] autoneg_en_o, // autoneg on
	input wire logic [NCHAN-1:0] autoneg_restart_o, // restart
	input wire logic power_down_o, // low power
	input wire logic [NCHAN-1:0] isolate_o, // isolate
	input wire logic [NCHAN-1:0] disparity_en_o // disparity
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	wire logic a0 = reg_addr_i == 5'h00;
	wire logic w0 = reg_wr_i && a0 && reg_chan_i == 2'h0;
	wire logic udef = !(reg_addr_i inside {5'h00, 5'h01, 5'h02, 5'h03,
		5'h0F, 5'h12});
	rd_valid_a:
		assert property (reg_rd_i |=> reg_rvalid_o) else $error("no valid");
	undef_rd_a:
		assert property (reg_rd_i && udef |=> reg_rdata_o == 16'h0000)
		else $error("undefined read nonzero");
	gen_rd_a:
		assert property (reg_rd_i && reg_addr_i == 5'h12
			|=> reg_rdata_o[15:1] == 15'h0000) else $error("generic high set");
	ctrl_rd_a:
		assert property (reg_rd_i && a0 |=> !reg_rdata_o[13]
			&& reg_rdata_o[8:6] == 3'h5 && reg_rdata_o[4:0] == 5'h00)
		else $error("control constants wrong");
	an_restart_a:
		assert property (w0 && reg_wdata_i[9] && !reg_wdata_i[15]
			&& !chan_reset_o[0] |=> autoneg_restart_o[0]) else $error("no restart");
	rst_req_a:
		assert property (w0 && reg_wdata_i[15] |=> chan_reset_o[0])
		else $error("no module reset");
	rst_hold_a:
		assert property (chan_reset_o[0] && !reset_done_i[0] |=> chan_reset_o[0])
		else $error("reset dropped early");
	rst_done_a:
		assert property ($rose(reset_done_i[0]) && chan_reset_o[0]
			|-> ##[1:6] !chan_reset_o[0]) else $error("reset never clears");
	rst_dflt_a:
		assert property ($rose(chan_reset_o[1]) |-> autoneg_en_o[1]
			&& isolate_o[1] && !disparity_en_o[1]) else $error("bad defaults");
	pdown_keep_a:
		assert property ($fell(power_down_o) |-> $rose(chan_reset_o[0]))
		else $error("power down cleared");
endmodule // sgmr_regs_props

bind sgmr_regs sgmr_regs_props #(.NCHAN(NCHAN)) props_u (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_chan_i(reg_chan_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .reset_done_i(reset_done_i),
	.chan_reset_o(chan_reset_o), .autoneg_en_o(autoneg_en_o),
	.autoneg_restart_o(autoneg_restart_o), .power_down_o(power_down_o),
	.isolate_o(isolate_o), .disparity_en_o(disparity_en_o));

// >>> test/sgmr_chan_model.sv
// far-side module model: takes a module reset and reports it done
// assumes one request per channel at a time
module sgmr_chan_model (
	input wire logic sys_clk_i, // clock
	input wire logic slow_i, // answer late
	input wire logic [3:0] req_i, // reset requests
	output logic [3:0] done_o // reset taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] dly_r [12];
	always_ff @(posedge sys_clk_i) begin
		dly_r[0] <= req_i;
		for (int i = 1; i < 12; i++)
			dly_r[i] <= dly_r[i - 1];
	end
	// done follows the request, so it drops only once the request has gone
	assign done_o = slow_i ? dly_r[11] : dly_r[1];
endmodule // sgmr_chan_model

// >>> test/sgmr_regs_tb.sv
// self-checking bench for the channel management register set
// assumes the far-side model answers resets; link pins driven here
module sgmr_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 0, rst_i = 1, wr = 0, rd = 0, slow = 0, rvld, pd;
	logic [1:0] ch = 0;
	logic [4:0] ad = 0;
	logic [15:0] wd = 0, rdat;
	logic [3:0] link = 0, done, creq, aneg, rs, iso, uni, dsp;
	int num_errors = 0, tests_run = 0;
	logic [4:0] ma [8] = '{5'h01, 5'h02, 5'h03, 5'h0F, 5'h04, 5'h10, 5'h1F,
		5'h11};
	logic [15:0] me [8] = '{16'h01C8, 16'h0, 16'h0, 16'h8000, 16'h0, 16'h0,
		16'h0, 16'h0};
	sgmr_regs dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_chan_i(ch),
		.reg_addr_i(ad), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd),
		.reg_rdata_o(rdat), .reg_rvalid_o(rvld), .link_up_i(link),
		.reset_done_i(done), .chan_reset_o(creq), .autoneg_en_o(aneg),
		.autoneg_restart_o(rs), .power_down_o(pd), .isolate_o(iso),
		.unidir_en_o(uni), .disparity_en_o(dsp));
	sgmr_chan_model far_u (.sys_clk_i(sys_clk_i), .slow_i(slow),
		.req_i(creq), .done_o(done));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrr(logic [1:0] c, logic [4:0] a, logic [15:0] d);
		@(negedge sys_clk_i);
		{ch, ad, wd, wr} = {c, a, d, 1'b1};
		@(negedge sys_clk_i);
		wr = 0;
	endtask
	task automatic rdc(logic [1:0] c, logic [4:0] a, logic [15:0] e);
		@(negedge sys_clk_i);
		{ch, ad, rd} = {c, a, 1'b1};
		@(negedge sys_clk_i);
		rd = 0;
		chk("rvalid", 16'(rvld), 16'h0001);
		chk("rdata", rdat, e);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 0;
		for (int c = 0; c < 4; c++) begin
			rdc(2'(c), 5'h00, 16'h1540);
			rdc(2'(c), 5'h12, 16'h0000);
		end
		chk("aneg", 16'(aneg), 16'h000F);
		chk("iso", 16'(iso), 16'h000F);
		$display("test defaults done");
		foreach (ma[i]) wrr(2'h2, ma[i], 16'hFFFF);
		foreach (ma[i]) rdc(2'h2, ma[i], me[i]);
		$display("test map done");
		wrr(2'h1, 5'h00, 16'h7FFF);
		chk("restart", 16'(rs), 16'h0002);
		rdc(2'h1, 5'h00, 16'h5D60);
		rdc(2'h2, 5'h00, 16'h1540);
		chk("unidir", 16'(uni), 16'h0002);
		wrr(2'h1, 5'h00, 16'h0000);
		rdc(2'h1, 5'h00, 16'h0140);
		chk("aneg", 16'(aneg), 16'h000D);
		chk("iso", 16'(iso), 16'h000D);
		$display("test control done");
		wrr(2'h0, 5'h00, 16'h0A00);
		chk("restart", 16'(rs), 16'h0001);
		wrr(2'h0, 5'h00, 16'h0000);
		chk("pdown", 16'(pd), 16'h0001);
		rdc(2'h0, 5'h00, 16'h0940);
		wrr(2'h3, 5'h12, 16'hFFFF);
		rdc(2'h3, 5'h12, 16'h0001);
		$display("test power and disparity done");
		for (int c = 0; c < 4; c++) begin
			slow = c != 3;
			wrr(2'(c), 5'h00, 16'h8000);
			chk("req", 16'(creq), 16'(1 << c));
			if (slow) begin
				wrr(2'(c), 5'h00, 16'h0000);
				rdc(2'(c), 5'h00, 16'h9540);
			end
			for (int k = 0; k < 40 && creq[c]; k++)
				@(negedge sys_clk_i);
			rdc(2'(c), 5'h00, 16'h1540);
			chk("pdown", 16'(pd), 16'h0000);
			chk("disp", 16'(dsp), (c == 3) ? 16'h0 : 16'h8);
		end
		$display("test module reset done");
		link = 4'h1;
		repeat (6) @(negedge sys_clk_i);
		rdc(2'h0, 5'h01, 16'h01C8);
		rdc(2'h0, 5'h01, 16'h01CC);
		link = 4'h0;
		repeat (6) @(negedge sys_clk_i);
		link = 4'h1;
		repeat (6) @(negedge sys_clk_i);
		rdc(2'h0, 5'h01, 16'h01C8);
		rdc(2'h0, 5'h01, 16'h01CC);
		$display("test link latch done");
		end_sim();
	end
endmodule // sgmr_regs_tb
